// file: hw/sac_adc_ctrl.sv
// Summary of operation
// - enable bit 0 holds converter in shutdown; 1 allows conversions
// - track mode 0: input tracked continuously except during conversion
// - busy bit reads 1 from the trigger through any track phase and conversion, 0 otherwise
// - end of conversion clears busy and sets the done flag; disabling clears busy only
// - busy write of 1 starts only when source is 00; 0 ignored
// - source field: busy write, timer 3, strobe rising edge, timer 2
// - track mode 1 non-strobe triggers track 3 sar clocks then convert
// - track mode 1 strobe: track while low, convert at rising edge
// - window match sets flag; only software clears it
// - justify bit: 0 right, 1 left aligned
// - right: result in high 1:0 and low byte, sign or zero above
// - left: result in high byte and low 7:6, low 5:0 zero
// - single-ended unsigned 10 bits; differential two's complement
// - every result compared to limits with no software action
// - limit ordering selects inside or outside detection
// - lower above upper: strictly between; else above or below
// - differential compares are signed in selected justification
// - conversion lasts sixteen sar clocks, sar clock is sysclk/(div+1)
`timescale 1ns/1ps
module sac_adc_ctrl
  import sac_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  input  wire logic        SFR_WE,
  input  wire logic        SFR_RE,
  output logic      [7:0]  SFR_RDATA,
  output logic             SFR_HIT,
  input  wire logic        TIMER2_OVF,
  input  wire logic        TIMER3_OVF,
  input  wire logic        EXTERNAL_CONVERT_STROBE,
  input  wire logic [9:0]  ANALOG_CODE,
  input  wire logic        DIFFERENTIAL,
  output logic             ANALOG_POWER_ON,
  output logic             ANALOG_TRACK,
  output logic             ANALOG_CONVERT
);
  typedef struct packed {
    sac_state_t  state;
    logic [4:0]  sar_cnt;
    logic [7:0]  control;
    logic [7:0]  config_reg;
    logic [7:0]  res_low;
    logic [7:0]  res_high;
    logic [7:0]  up_high;
    logic [7:0]  up_low;
    logic [7:0]  lo_high;
    logic [7:0]  lo_low;
    logic [7:0]  rdata;
    logic        strobe_s1;
    logic        strobe_s2;
    logic        strobe_d;
  } sac_regs_t;

  sac_regs_t cur_ff;
  sac_regs_t nxt_cur;
  logic        tick_w;
  logic        run_w;
  logic        match_w;
  logic [15:0] word_w;
  logic        enable_w;
  logic        track_mode_w;
  logic [1:0]  src_w;
  logic        left_w;
  logic        busy_write_w;
  logic        trigger_w;
  logic        strobe_rise_w;
  logic        finish_w;
  logic [9:0]  code_w;

  ////////////////////////////////////////////////////////////////
  // field views of the control register
  assign enable_w      = cur_ff.control[BIT_ENABLE];
  assign track_mode_w  = cur_ff.control[BIT_TRACK];
  assign src_w         = cur_ff.control[BIT_SRC_HI:BIT_SRC_LO];
  assign left_w        = cur_ff.control[BIT_LEFT];
  assign strobe_rise_w = cur_ff.strobe_s2 && !cur_ff.strobe_d;
  assign busy_write_w  = SFR_WE && (SFR_ADDR == ADDR_CONTROL)
                         && SFR_WDATA[BIT_BUSY];
  assign run_w         = (cur_ff.state != ST_IDLE);
  assign code_w        = ANALOG_CODE;
  assign finish_w      = (cur_ff.state == ST_CONV) && tick_w
                         && (cur_ff.sar_cnt == CONVERT_SAR_CLOCKS - 5'h01);

  ////////////////////////////////////////////////////////////////
  // trigger selection; timer pulses are same-clock, strobe is synced
  always_comb begin
    case (src_w)
      SRC_BUSY_WRITE: trigger_w = busy_write_w;
      SRC_TIMER3:     trigger_w = TIMER3_OVF;
      SRC_STROBE:     trigger_w = strobe_rise_w;
      SRC_TIMER2:     trigger_w = TIMER2_OVF;
      default:        trigger_w = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // formatting of the live code for the window check and result bytes
  always_comb begin
    if (left_w) begin
      word_w = {code_w, 6'h00};
    end else begin
      word_w = {{6{DIFFERENTIAL & code_w[RESULT_BITS-1]}}, code_w};
    end
  end

  sac_sar_tick u_tick (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .ce      (CE),
    .run     (run_w),
    .divider (cur_ff.config_reg[CFG_DIV_HI:CFG_DIV_LO]),
    .tick    (tick_w)
  );

  sac_window u_window (
    .word        (word_w),
    .upper       ({cur_ff.up_high, cur_ff.up_low}),
    .lower       ({cur_ff.lo_high, cur_ff.lo_low}),
    .signed_mode (DIFFERENTIAL),
    .match       (match_w)
  );

  ////////////////////////////////////////////////////////////////
  // next-state logic: register writes, sequencer, result capture
  always_comb begin
    nxt_cur           = cur_ff;
    nxt_cur.strobe_s1 = EXTERNAL_CONVERT_STROBE;
    nxt_cur.strobe_s2 = cur_ff.strobe_s1;
    nxt_cur.strobe_d  = cur_ff.strobe_s2;

    // register writes; busy bit is owned by the sequencer
    if (SFR_WE) begin
      case (SFR_ADDR)
        ADDR_CONTROL: begin
          nxt_cur.control = {SFR_WDATA[BIT_ENABLE:BIT_DONE], cur_ff.control[BIT_BUSY],
                             SFR_WDATA[BIT_SRC_HI:BIT_LEFT]};
        end
        ADDR_CONFIG:      nxt_cur.config_reg = SFR_WDATA;
        ADDR_RESULT_LOW:  nxt_cur.res_low    = SFR_WDATA;
        ADDR_RESULT_HIGH: nxt_cur.res_high   = SFR_WDATA;
        ADDR_UPPER_HIGH:  nxt_cur.up_high    = SFR_WDATA;
        ADDR_UPPER_LOW:   nxt_cur.up_low     = SFR_WDATA;
        ADDR_LOWER_HIGH:  nxt_cur.lo_high    = SFR_WDATA;
        ADDR_LOWER_LOW:   nxt_cur.lo_low     = SFR_WDATA;
        default: ;
      endcase
    end

    // sequencer
    case (cur_ff.state)
      ST_IDLE: begin
        nxt_cur.sar_cnt = 5'h00;
        if (enable_w && trigger_w) begin
          nxt_cur.control[BIT_BUSY] = 1'b1;
          if (track_mode_w && (src_w != SRC_STROBE)) begin
            nxt_cur.state = ST_TRACK;
          end else begin
            nxt_cur.state = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (tick_w) begin
          if (cur_ff.sar_cnt == TRACK_SAR_CLOCKS - 5'h01) begin
            nxt_cur.sar_cnt = 5'h00;
            nxt_cur.state   = ST_CONV;
          end else begin
            nxt_cur.sar_cnt = cur_ff.sar_cnt + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tick_w) begin
          nxt_cur.sar_cnt = cur_ff.sar_cnt + 5'h01;
        end
        if (finish_w) begin
          // capture, flags and busy all change together; set beats clear
          nxt_cur.state               = ST_IDLE;
          nxt_cur.sar_cnt             = 5'h00;
          nxt_cur.control[BIT_BUSY]   = 1'b0;
          nxt_cur.control[BIT_DONE]   = 1'b1;
          nxt_cur.res_high            = word_w[15:8];
          nxt_cur.res_low             = word_w[7:0];
          if (match_w) begin
            nxt_cur.control[BIT_WINDOW] = 1'b1;
          end
        end
      end
      default: nxt_cur.state = ST_IDLE;
    endcase

    // disabling aborts a conversion without raising the done flag
    if (!nxt_cur.control[BIT_ENABLE]) begin
      nxt_cur.state             = ST_IDLE;
      nxt_cur.control[BIT_BUSY] = 1'b0;
      nxt_cur.sar_cnt           = 5'h00;
    end

    // registered read data; sees the value before this cycle's write
    case (SFR_ADDR)
      ADDR_CONTROL:     nxt_cur.rdata = cur_ff.control;
      ADDR_CONFIG:      nxt_cur.rdata = cur_ff.config_reg;
      ADDR_RESULT_LOW:  nxt_cur.rdata = cur_ff.res_low;
      ADDR_RESULT_HIGH: nxt_cur.rdata = cur_ff.res_high;
      ADDR_UPPER_HIGH:  nxt_cur.rdata = cur_ff.up_high;
      ADDR_UPPER_LOW:   nxt_cur.rdata = cur_ff.up_low;
      ADDR_LOWER_HIGH:  nxt_cur.rdata = cur_ff.lo_high;
      ADDR_LOWER_LOW:   nxt_cur.rdata = cur_ff.lo_low;
      default:          nxt_cur.rdata = RST_BYTE;
    endcase
    if (!SFR_RE) begin
      nxt_cur.rdata = cur_ff.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cur_ff            <= '0;
      cur_ff.state      <= ST_IDLE;
      cur_ff.control    <= RST_CONTROL;
      cur_ff.config_reg <= RST_CONFIG;
      cur_ff.res_low    <= RST_BYTE;
      cur_ff.res_high   <= RST_BYTE;
      cur_ff.rdata      <= RST_BYTE;
    end else if (CE) begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs to the analog core and the bus
  assign SFR_RDATA       = cur_ff.rdata;
  assign SFR_HIT         = (SFR_ADDR == ADDR_CONTROL) || (SFR_ADDR == ADDR_CONFIG)
                           || (SFR_ADDR == ADDR_RESULT_LOW)
                           || (SFR_ADDR == ADDR_RESULT_HIGH)
                           || (SFR_ADDR == ADDR_UPPER_HIGH)
                           || (SFR_ADDR == ADDR_UPPER_LOW)
                           || (SFR_ADDR == ADDR_LOWER_HIGH)
                           || (SFR_ADDR == ADDR_LOWER_LOW);
  assign ANALOG_POWER_ON = enable_w;
  assign ANALOG_CONVERT  = (cur_ff.state == ST_CONV);
  // mode 0 tracks whenever idle; strobe mode 1 tracks only while strobe low
  assign ANALOG_TRACK    = enable_w && (
                             (cur_ff.state == ST_TRACK)
                             || ((cur_ff.state == ST_IDLE) && !track_mode_w)
                             || ((cur_ff.state == ST_IDLE) && track_mode_w
                                 && (src_w == SRC_STROBE)
                                 && !cur_ff.strobe_s2));
endmodule : sac_adc_ctrl

// file: hw/sac_pkg.sv
package sac_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_RESULT_LOW    = 8'hBE;
  localparam logic [7:0] ADDR_RESULT_HIGH   = 8'hBF;
  localparam logic [7:0] ADDR_CONTROL       = 8'hE8;
  localparam logic [7:0] ADDR_CONFIG        = 8'hBC;
  localparam logic [7:0] ADDR_UPPER_HIGH    = 8'hC5;
  localparam logic [7:0] ADDR_UPPER_LOW     = 8'hC4;
  localparam logic [7:0] ADDR_LOWER_HIGH    = 8'hC7;
  localparam logic [7:0] ADDR_LOWER_LOW     = 8'hC6;
  // control register bit positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_TRACK    = 6;
  localparam int BIT_DONE     = 5;
  localparam int BIT_BUSY     = 4;
  localparam int BIT_SRC_HI   = 3;
  localparam int BIT_SRC_LO   = 2;
  localparam int BIT_WINDOW   = 1;
  localparam int BIT_LEFT     = 0;
  // configuration register: divider in bits 7:3
  localparam int CFG_DIV_HI   = 7;
  localparam int CFG_DIV_LO   = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG  = 8'hF8;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // start sources
  localparam logic [1:0] SRC_BUSY_WRITE = 2'h0;
  localparam logic [1:0] SRC_TIMER3     = 2'h1;
  localparam logic [1:0] SRC_STROBE     = 2'h2;
  localparam logic [1:0] SRC_TIMER2     = 2'h3;
  // timing in sar clocks
  localparam logic [4:0] TRACK_SAR_CLOCKS   = 5'h03;
  localparam logic [4:0] CONVERT_SAR_CLOCKS = 5'h10;
  localparam int RESULT_BITS = 10;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b100
  } sac_state_t;
endpackage : sac_pkg

// file: hw/sac_sar_tick.sv
`timescale 1ns/1ps
// sar clock tick: one pulse per divider+1 system clocks
module sac_sar_tick
  import sac_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [4:0] divider,
  output logic            tick
);
  typedef struct packed {
    logic [4:0] cnt;
  } sac_tick_t;
  sac_tick_t cur_ff;
  sac_tick_t nxt_cur;
  ////////////////////////////////////////////////////////////////
  // restart at zero whenever not running so phase is fixed per start
  always_comb begin
    nxt_cur = cur_ff;
    tick    = run && (cur_ff.cnt == divider);
    if (!run || tick) begin
      nxt_cur.cnt = 5'h00;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_cur;
    end
  end
endmodule : sac_sar_tick

// file: hw/sac_window.sv
`timescale 1ns/1ps
// window comparator on the formatted 16-bit data word
module sac_window
  import sac_pkg::*;
(
  input  wire logic [15:0] word,
  input  wire logic [15:0] upper,
  input  wire logic [15:0] lower,
  input  wire logic        signed_mode,
  output logic             match
);
  logic gt_w;
  logic lt_w;
  logic inv_w;
  ////////////////////////////////////////////////////////////////
  // signed compares for differential words, unsigned otherwise
  always_comb begin
    if (signed_mode) begin
      gt_w  = $signed(word) > $signed(upper);
      lt_w  = $signed(word) < $signed(lower);
      inv_w = $signed(lower) > $signed(upper);
    end else begin
      gt_w  = word > upper;
      lt_w  = word < lower;
      inv_w = lower > upper;
    end
    // ordering of limits picks inside or outside window
    match = inv_w ? (gt_w && lt_w) : (gt_w || lt_w);
  end
endmodule : sac_window

// file: testbench/sac_adc_ctrl_monitor.sv
`timescale 1ns/1ps
module sac_adc_ctrl_monitor
  import sac_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic       CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WE,
  input wire logic       SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       SFR_HIT,
  input wire logic       TIMER2_OVF,
  input wire logic       TIMER3_OVF,
  input wire logic       EXTERNAL_CONVERT_STROBE,
  input wire logic [9:0] ANALOG_CODE,
  input wire logic       DIFFERENTIAL,
  input wire logic       ANALOG_POWER_ON,
  input wire logic       ANALOG_TRACK,
  input wire logic       ANALOG_CONVERT
);
  logic [7:0] ctl_ff;
  logic [7:0] cnt_ff;
  logic       wr_ctl;
  logic       idle_on;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the last control write; cycles spent converting, saturating
  assign wr_ctl  = CE && SFR_WE && SFR_ADDR == ADDR_CONTROL;
  assign idle_on = !ANALOG_CONVERT && ctl_ff[BIT_ENABLE];
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctl_ff <= RST_CONTROL;
      cnt_ff <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_ff <= SFR_WDATA;
      end
      cnt_ff <= !ANALOG_CONVERT ? 8'h00 : cnt_ff + {7'h00, cnt_ff != 8'hff};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shadow only knows written fields, so triggers are judged from a settled mode
  power_gate_a: assert property (!ANALOG_POWER_ON |-> !ANALOG_TRACK && !ANALOG_CONVERT)
    else $error("analog active while disabled");
  enable_follow_a: assert property (wr_ctl |=> ANALOG_POWER_ON == ctl_ff[BIT_ENABLE])
    else $error("power does not follow enable");
  hold_split_a: assert property (ANALOG_CONVERT |-> !ANALOG_TRACK)
    else $error("tracking during conversion");
  conv_length_a: assert property (
    $fell(ANALOG_CONVERT) && ANALOG_POWER_ON |-> cnt_ff >= 8'h10)
    else $error("conversion too short");
  sw_start_a: assert property (wr_ctl && SFR_WDATA[7:2] == 6'b100100
    && ctl_ff[7:6] == 2'b10 && idle_on |=> ANALOG_CONVERT)
    else $error("busy write did not start");
  zero_write_a: assert property (wr_ctl && !SFR_WDATA[BIT_BUSY] && SFR_WDATA[3:2] == 2'b00
    && !ctl_ff[BIT_TRACK] && ctl_ff[3:2] == 2'b00 && !ANALOG_CONVERT |=> !ANALOG_CONVERT)
    else $error("zero busy write started");
  timer_start_a: assert property (CE && !SFR_WE && ctl_ff[7:6] == 2'b10 && idle_on
    && (TIMER3_OVF && ctl_ff[3:2] == SRC_TIMER3 || TIMER2_OVF && ctl_ff[3:2] == SRC_TIMER2)
    |=> ANALOG_CONVERT)
    else $error("timer overflow did not start");
  slow_track_a: assert property (wr_ctl && SFR_WDATA[7:2] == 6'b110100
    && ctl_ff[7:6] == 2'b11 && idle_on && !ANALOG_TRACK
    |=> (ANALOG_TRACK && !ANALOG_CONVERT)[*3] ##[1:94] ANALOG_CONVERT)
    else $error("low power track phase wrong");
  // reads of the control and lower limit high registers must be claimed by the block
  reg_hit_a: assert property (SFR_RE && (SFR_ADDR == ADDR_CONTROL
    || SFR_ADDR == ADDR_LOWER_HIGH) |-> SFR_HIT)
    else $error("mapped register not claimed");
endmodule : sac_adc_ctrl_monitor

bind sac_adc_ctrl sac_adc_ctrl_monitor i_mon (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
  .TIMER2_OVF(TIMER2_OVF), .TIMER3_OVF(TIMER3_OVF), .ANALOG_CODE(ANALOG_CODE),
  .EXTERNAL_CONVERT_STROBE(EXTERNAL_CONVERT_STROBE), .DIFFERENTIAL(DIFFERENTIAL),
  .ANALOG_POWER_ON(ANALOG_POWER_ON), .ANALOG_TRACK(ANALOG_TRACK), .ANALOG_CONVERT(ANALOG_CONVERT)
);

// file: testbench/sac_adc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module sac_adc_ctrl_tb
  import sac_pkg::*;
;
  logic        CLK_SYS, RST_N, TIMER2_OVF, TIMER3_OVF, EXTERNAL_CONVERT_STROBE, DIFFERENTIAL;
  logic        CE, SFR_HIT;
  logic        ANALOG_POWER_ON, ANALOG_TRACK, ANALOG_CONVERT, SFR_WE, SFR_RE, tm, diff, left, win;
  logic [9:0]  ANALOG_CODE, code;
  logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA, rd;
  logic [1:0]  src;
  logic [15:0] up, lo, w;
  int          n_errors, num_checks, cyc, wv, uv, lv;
  sac_adc_ctrl i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
    .SFR_HIT(SFR_HIT), .TIMER2_OVF(TIMER2_OVF), .TIMER3_OVF(TIMER3_OVF),
    .ANALOG_CODE(ANALOG_CODE), .EXTERNAL_CONVERT_STROBE(EXTERNAL_CONVERT_STROBE),
    .DIFFERENTIAL(DIFFERENTIAL), .ANALOG_POWER_ON(ANALOG_POWER_ON),
    .ANALOG_TRACK(ANALOG_TRACK), .ANALOG_CONVERT(ANALOG_CONVERT));
  sac_core_model i_core (.CLK_SYS(CLK_SYS), .SFR_RDATA(SFR_RDATA), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE));
  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling well above the thousand or so cycles of the run
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // signed reading for differential data, unsigned otherwise
  function automatic int val(input logic [15:0] v, input logic s);
    return s ? int'($signed(v)) : int'(v);
  endfunction : val
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {TIMER2_OVF, TIMER3_OVF, EXTERNAL_CONVERT_STROBE, DIFFERENTIAL, RST_N} = 5'h00;
    CE = 1'b1;
    {ANALOG_CODE, n_errors, num_checks, cyc} = '0;
    void'($urandom(44));
    tick(8);
    RST_N = 1'b1;
    i_core.rd(ADDR_CONTROL, rd); `CHK("control", RST_CONTROL, rd)
    i_core.rd(ADDR_RESULT_LOW, rd); `CHK("result low", RST_BYTE, rd)
    i_core.rd(ADDR_LOWER_HIGH, rd); `CHK("lower high", RST_BYTE, rd)
    i_core.rd(8'h00, rd); `CHK("unmapped", 8'h00, rd)
    `CHK("hit", 1'b0, SFR_HIT)
    i_core.rd(ADDR_CONFIG, rd); `CHK("config", RST_CONFIG, rd)
    // a start request while shut down is ignored
    i_core.wr(ADDR_CONTROL, 8'h10);
    tick(3);
    `CHK("power", 1'b0, ANALOG_POWER_ON)
    `CHK("asleep", 1'b0, ANALOG_CONVERT)
    // every source under both track modes, random data and limits
    for (int i = 0; i < 16; i++) begin
      {tm, src} = {i[2], i[1:0]};
      i_core.gap = i % 3;
      {code, diff, left} = 12'($urandom);
      if (i == 1) {code, diff, left} = {10'h3ff, 2'b10};
      {up, lo} = $urandom;
      {ANALOG_CODE, DIFFERENTIAL} = {code, diff};
      i_core.wr(ADDR_UPPER_HIGH, up[15:8]);
      i_core.wr(ADDR_UPPER_LOW, up[7:0]);
      i_core.wr(ADDR_LOWER_HIGH, lo[15:8]);
      i_core.wr(ADDR_LOWER_LOW, lo[7:0]);
      // divider of 0 or 1 keeps conversions short but still exercises the prescaler
      i_core.wr(ADDR_CONFIG, {4'h0, i[3], 3'h0});
      // clears both flags and settles the source before any busy write is made
      i_core.wr(ADDR_CONTROL, {1'b1, tm, 2'b00, src, 1'b0, left});
      // a busy write under a hardware source must not start
      i_core.wr(ADDR_CONTROL, {1'b1, tm, 1'b0, src != SRC_BUSY_WRITE, src, 1'b0, left});
      tick(4);
      `CHK("idle track", !tm || src == SRC_STROBE, ANALOG_TRACK)
      `CHK("no start", 1'b0, ANALOG_CONVERT)
      case (src)
        SRC_BUSY_WRITE: i_core.wr(ADDR_CONTROL, {1'b1, tm, 4'b0100, 1'b0, left});
        SRC_STROBE: EXTERNAL_CONVERT_STROBE = 1'b1;
        SRC_TIMER3: {TIMER3_OVF, TIMER2_OVF} = 2'b10;
        default: {TIMER3_OVF, TIMER2_OVF} = 2'b01;
      endcase
      tick(1);
      {TIMER3_OVF, TIMER2_OVF} = 2'b00;
      rd = 8'h00;
      for (int k = 0; k < 60 && rd[BIT_DONE] !== 1'b1; k++) begin
        i_core.rd(ADDR_CONTROL, rd);
        if (src == 2'b00 && !tm && !rd[BIT_DONE]) `CHK("busy", 1'b1, rd[BIT_BUSY])
      end
      `CHK("done", 1'b1, rd[BIT_DONE])
      `CHK("busy end", 1'b0, rd[BIT_BUSY])
      w = left ? {code, 6'h00} : {{6{diff & code[9]}}, code};
      {wv, uv, lv} = {val(w, diff), val(up, diff), val(lo, diff)};
      win = (lv > uv) ? (wv > uv && wv < lv) : (wv > uv || wv < lv);
      `CHK("window", win, rd[BIT_WINDOW])
      i_core.rd(ADDR_RESULT_HIGH, rd); `CHK("high", w[15:8], rd)
      i_core.rd(ADDR_RESULT_LOW, rd); `CHK("low", w[7:0], rd)
      i_core.rd(ADDR_CONTROL, rd); `CHK("done held", 1'b1, rd[BIT_DONE])
      EXTERNAL_CONVERT_STROBE = 1'b0;
    end
    // a write while the clock enable is low must leave the register as it was
    CE = 1'b0;
    i_core.wr(ADDR_UPPER_LOW, ~up[7:0]);
    CE = 1'b1;
    i_core.rd(ADDR_UPPER_LOW, rd); `CHK("frozen", up[7:0], rd)
    give_verdict();
  end
endmodule : sac_adc_ctrl_tb

// file: testbench/sac_core_model.sv
`timescale 1ns/1ps
module sac_core_model (
  input  wire logic       CLK_SYS,
  input  wire logic [7:0] SFR_RDATA,
  output logic      [7:0] SFR_ADDR,
  output logic      [7:0] SFR_WDATA,
  output logic            SFR_WE,
  output logic            SFR_RE
);
  int gap;
  ////////////////////////////////////////////////////////////////////////////////
  // gap adds idle cycles so the core can be slow as well as prompt
  initial begin
    gap = 0;
    {SFR_ADDR, SFR_WDATA, SFR_WE, SFR_RE} = 18'h0_0000;
  end
  // released lines are inverted so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    #2;
    {SFR_ADDR, SFR_WDATA, SFR_WE} = {a, d, 1'b1};
    @(posedge CLK_SYS);
    #2;
    {SFR_ADDR, SFR_WDATA, SFR_WE} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (gap) @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    #2;
    {SFR_ADDR, SFR_RE} = {a, 1'b1};
    @(posedge CLK_SYS);
    #2;
    {SFR_ADDR, SFR_RE} = {~a, 1'b0};
    d = SFR_RDATA;
  endtask : rd
endmodule : sac_core_model
